// ===== rtl/ndc_pkg.sv
// Package for the nibble delay configuration block.
// Assumes a 125 MHz system clock and six lane slices per nibble.
package ndc_pkg;
    localparam int SLICES = 6;
    localparam int TAP_W = 11;
    localparam logic [10:0] MAX_PS_SINGLE = 11'h271;
    localparam logic [10:0] MAX_PS_JOINED = 11'h4E2;
    localparam logic [10:0] TAPS_SINGLE = 11'h200;
    localparam logic [10:0] TAPS_JOINED = 11'h400;
    localparam int PRE_STROBES = 3;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int DRIFT_SETTLE_NS = 40;
    localparam int DRIFT_SETTLE_CYC = (DRIFT_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ERR_W = 6;
    localparam int ERR_NZ_NO_CAL = 0;
    localparam int ERR_COARSE_NO_CAL = 1;
    localparam int ERR_COARSE_PHASE = 2;
    localparam int ERR_OVER_MAX = 3;
    localparam int ERR_STROBE_SLICE = 4;
    localparam int ERR_TX_QTR = 5;
    typedef enum logic [1:0]
    {
        NDC_IDLE = 2'b00,
        NDC_SETTLE = 2'b01,
        NDC_READY = 2'b11,
        NDC_DROP = 2'b10
    } ndc_cal_e;
endpackage

// ===== rtl/ndc_slice_if.sv
// Interface carrying one slice's chain settings to the slice module.
// Assumes the main block drives config and reads results.
`timescale 1ns/1ps
interface ndc_slice_if;
    logic joined;
    logic [10:0] delayPs;
    logic txQtr;
    logic [10:0] inPs;
    logic [10:0] outPs;
    logic [10:0] tapRange;
    logic txAllowed;
    logic overMax;
    modport cfg (output joined, output delayPs, output txQtr,
                 input inPs, input outPs, input tapRange, input txAllowed, input overMax);
    modport slc (input joined, input delayPs, input txQtr,
                 output inPs, output outPs, output tapRange, output txAllowed, output overMax);
endinterface

// ===== rtl/ndc_slice.sv
// One lane slice's delay chain split and range check.
// Assumes static inputs from the configuration block.
`timescale 1ns/1ps
module ndc_slice
(
    ndc_slice_if.slc sl
);
    wire [10:0] halfPs = {1'b0, sl.delayPs[10:1]};
    wire [10:0] restPs = sl.delayPs - halfPs;
    // Joined slice splits the delay over both lines; otherwise input line only.
    assign sl.inPs = sl.joined ? halfPs : sl.delayPs; // R2 R5 R14
    assign sl.outPs = sl.joined ? restPs : 11'h000; // R2 R3
    assign sl.tapRange = sl.joined ? ndc_pkg::TAPS_JOINED : ndc_pkg::TAPS_SINGLE; // R2
    assign sl.txAllowed = ~sl.joined; // R3
    assign sl.overMax = sl.delayPs >
        (sl.joined ? ndc_pkg::MAX_PS_JOINED : ndc_pkg::MAX_PS_SINGLE); // R14
endmodule

// ===== rtl/ndc_config.sv
// Per-nibble delay, strobe gating and coarse delay configuration with legality checks.
// Assumes static attribute inputs; strobe and read window enable come from pins.
`timescale 1ns/1ps
// Function
// R1 - Slice suffix configures only matching slice.
// R2 - Joining chains input and output delays.
// R3 - Joined slice keeps only its output delay; here it keeps both its input and output delays and loses transmit.
// R4 - Software splits joined delay half and half.
// R5 - Unjoined receiver uses input delay only.
// R6 - Free-running option gates strobe with window.
// R7 - Source gives continuous clock when free-running.
// R8 - Gating cycle-exact only without free-running.
// R9 - Three strobes precede data when free-running.
// R10 - Coarse enable adds coarse strobe delay.
// R11 - Coarse delay for edge-aligned below 1 GHz.
// R12 - Coarse needs calibration and equal phases.
// R13 - Coarse only between 200 MHz and 1 GHz.
// R14 - Tap setting sets both delays, bounded max.
// R15 - Zero tap on strobe and quarter slices.
// R16 - Non-zero tap needs automatic calibration.
// R17 - No tap setting below 500 MHz.
// R18 - Drift tracking off disables input compensation.
// R19 - Calibrated flag follows compensation request sequence.
// R20 - Illegal attribute combinations are flagged.
module ndc_config #(
    parameter int SLICES = ndc_pkg::SLICES
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [SLICES-1:0] sliceJoin,
    input wire logic [SLICES*11-1:0] sliceDelayPs,
    input wire logic [SLICES-1:0] sliceTxQtr,
    input wire logic strobeGateEnable,
    input wire logic freeRunStrobe,
    input wire logic coarseDelayEnable,
    input wire logic selfCalEnable,
    input wire logic phaseShiftP,
    input wire logic phaseShiftN,
    input wire logic inputDriftTrackingOff,
    input wire logic driftCompRequest,
    input wire logic readWindowEnable,
    input wire logic strobeIn,
    output logic [SLICES*11-1:0] inDelayPs,
    output logic [SLICES*11-1:0] outDelayPs,
    output logic [SLICES-1:0] txEnabled,
    output logic gatedStrobe,
    output logic gateReady,
    output logic coarseApplied,
    output logic inputDriftActive,
    output logic laneCalibratedFlag,
    output logic [ndc_pkg::ERR_W-1:0] configError
);
    // ************************************************************
    // Slice chains
    // ************************************************************
    logic [SLICES-1:0] overMax;
    logic [SLICES-1:0] nonZero;
    logic [SLICES*11-1:0] inPsW;
    logic [SLICES*11-1:0] outPsW;
    logic [SLICES-1:0] txW;
    for (genvar i = 0; i < SLICES; i++)
    begin : gSlice
        ndc_slice_if sif();
        // Each slice sees only its own suffix fields.
        assign sif.joined = sliceJoin[i]; // R1
        assign sif.delayPs = sliceDelayPs[i*ndc_pkg::TAP_W +: ndc_pkg::TAP_W]; // R1
        assign sif.txQtr = sliceTxQtr[i];
        ndc_slice uSlice
        (
            .sl(sif)
        );
        assign inPsW[i*ndc_pkg::TAP_W +: ndc_pkg::TAP_W] = sif.inPs;
        assign outPsW[i*ndc_pkg::TAP_W +: ndc_pkg::TAP_W] = sif.outPs;
        assign txW[i] = sif.txAllowed;
        assign overMax[i] = sif.overMax;
        assign nonZero[i] = sif.delayPs != 11'h000;
    end

    // ************************************************************
    // Legality checks
    // ************************************************************
    // The block cannot see the bit clock rate, so R11, R13 and R17 stay with software.
    wire [ndc_pkg::ERR_W-1:0] errNext;
    assign errNext[ndc_pkg::ERR_NZ_NO_CAL] = (|nonZero) & ~selfCalEnable; // R16 R20
    assign errNext[ndc_pkg::ERR_COARSE_NO_CAL] = coarseDelayEnable & ~selfCalEnable; // R12 R20
    assign errNext[ndc_pkg::ERR_COARSE_PHASE] =
        coarseDelayEnable & (phaseShiftP != phaseShiftN); // R12 R20
    assign errNext[ndc_pkg::ERR_OVER_MAX] = |overMax; // R14 R20
    assign errNext[ndc_pkg::ERR_STROBE_SLICE] = nonZero[0]; // R15 R20
    assign errNext[ndc_pkg::ERR_TX_QTR] = |(nonZero & sliceTxQtr); // R15 R20

    // ************************************************************
    // Strobe gating
    // ************************************************************
    logic strobeS1;
    logic strobeS2;
    logic winS1;
    logic winS2;
    logic [1:0] strobeCnt;
    wire strobeRise = strobeS2 & ~gatedStrobe;
    // Free-running: gate opens freely on the window, not aligned to the strobe.
    wire gateOpenFree = ~strobeGateEnable | winS2; // R6 R8
    // Burst strobe: gate opens only while the strobe is low, giving fixed positions.
    wire gateOpenBurst = ~strobeGateEnable | (winS2 & (~strobeS2 | gatedStrobe)); // R8
    wire gateOpen = freeRunStrobe ? gateOpenFree : gateOpenBurst; // R6
    wire gatedNext = strobeS2 & gateOpen;
    wire cntFull = strobeCnt == 2'(ndc_pkg::PRE_STROBES);
    wire [1:0] cntNext = ~gateOpen ? 2'h0 : (strobeRise & ~cntFull) ? strobeCnt + 2'h1 : strobeCnt;

    // ************************************************************
    // Drift compensation sequencing
    // ************************************************************
    localparam int CW = $clog2(ndc_pkg::DRIFT_SETTLE_CYC + 1);
    ndc_pkg::ndc_cal_e calState;
    ndc_pkg::ndc_cal_e calNext;
    logic [CW-1:0] settleCnt;
    logic reqS1;
    logic reqS2;
    wire settleDone = settleCnt == CW'(ndc_pkg::DRIFT_SETTLE_CYC);
    always_comb
    begin
        calNext = calState;
        case (calState)
            ndc_pkg::NDC_IDLE: if (reqS2 & selfCalEnable) calNext = ndc_pkg::NDC_SETTLE; // R19
            ndc_pkg::NDC_SETTLE: if (settleDone) calNext = ndc_pkg::NDC_READY; // R19
            // Flag holds after the request drops; a new request re-runs the settle.
            ndc_pkg::NDC_READY: if (~reqS2) calNext = ndc_pkg::NDC_DROP; // R19
            ndc_pkg::NDC_DROP: if (reqS2) calNext = ndc_pkg::NDC_SETTLE; // R19
            default: calNext = ndc_pkg::NDC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strobeS1 <= 1'b0;
            strobeS2 <= 1'b0;
            winS1 <= 1'b0;
            winS2 <= 1'b0;
            reqS1 <= 1'b0;
            reqS2 <= 1'b0;
            gatedStrobe <= 1'b0;
            strobeCnt <= 2'h0;
            gateReady <= 1'b0;
            calState <= ndc_pkg::NDC_IDLE;
            settleCnt <= '0;
            laneCalibratedFlag <= 1'b0;
            inputDriftActive <= 1'b0;
            coarseApplied <= 1'b0;
            configError <= '0;
            inDelayPs <= '0;
            outDelayPs <= '0;
            txEnabled <= '0;
        end
        else
        begin
            strobeS1 <= strobeIn;
            strobeS2 <= strobeS1;
            winS1 <= readWindowEnable;
            winS2 <= winS1;
            reqS1 <= driftCompRequest;
            reqS2 <= reqS1;
            gatedStrobe <= gatedNext; // R6
            strobeCnt <= cntNext; // R9
            gateReady <= gateOpen & (~freeRunStrobe | cntFull); // R9
            calState <= calNext;
            settleCnt <= (calState == ndc_pkg::NDC_SETTLE) ? settleCnt + CW'(1) : '0;
            laneCalibratedFlag <= (calNext == ndc_pkg::NDC_READY)
                | (calNext == ndc_pkg::NDC_DROP); // R19
            inputDriftActive <= ~inputDriftTrackingOff & reqS2
                & (calState == ndc_pkg::NDC_READY); // R18
            coarseApplied <= coarseDelayEnable & ~errNext[ndc_pkg::ERR_COARSE_PHASE]; // R10
            configError <= errNext; // R20
            inDelayPs <= inPsW; // R14
            outDelayPs <= outPsW; // R14
            txEnabled <= txW; // R3
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    coarse_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
        !$past(coarseDelayEnable) |-> !coarseApplied)
        else $error("Coarse delay applied while disabled.");
    tap_cal_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
        ($past(|nonZero) && !$past(selfCalEnable)) |-> configError[ndc_pkg::ERR_NZ_NO_CAL])
        else $error("Non-zero tap without calibration not flagged.");
    phase_eq_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
        $past(coarseDelayEnable && (phaseShiftP != phaseShiftN))
        |-> configError[ndc_pkg::ERR_COARSE_PHASE] && !coarseApplied)
        else $error("Unequal phases with coarse delay not flagged.");
    gate_closed_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
        (strobeGateEnable && !winS2) |=> !gatedStrobe)
        else $error("Strobe passed while the read window was closed.");
    pre_strobe_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
        $rose(gateReady) && freeRunStrobe |-> $past(cntFull))
        else $error("Gate ready before three strobes.");
    joined_tx_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
        $past(sliceJoin[2]) |-> !txEnabled[2]
        && (inDelayPs[32:22] + outDelayPs[32:22]) == $past(sliceDelayPs[32:22]))
        else $error("Joined slice kept transmit or lost delay.");
    single_line_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
        !$past(sliceJoin[1]) |-> outDelayPs[21:11] == 11'h000
        && inDelayPs[21:11] == $past(sliceDelayPs[21:11]))
        else $error("Unjoined slice used its output line.");
    flag_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R19
        laneCalibratedFlag && !reqS2 |=> laneCalibratedFlag)
        else $error("Calibrated flag dropped when request fell.");
    drift_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
        $past(inputDriftTrackingOff) |-> !inputDriftActive)
        else $error("Drift compensation active while disabled.");
    cov_flag_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(laneCalibratedFlag));
    cov_regate_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $fell(laneCalibratedFlag));
    cov_free_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        freeRunStrobe && $rose(gateReady));
    cov_coarse_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        coarseApplied);
endmodule

// ===== verif/ndc_strobe_src.sv
// Model of the far-side source-synchronous transmitter that drives the strobe.
// Assumes the bench raises run to start a continuous capture clock.
`timescale 1ns/1ps
// ****************************************
// Strobe source
// ****************************************
module ndc_strobe_src
(
    input wire logic sys_clk,
    input wire logic run,
    output logic strobe
);
    logic [1:0] phase;
    // The clock runs without gaps while run is high, and only stops between frames.
    // Slow enough that the two-flop synchronizer never loses an edge.
    always @(posedge sys_clk)
    begin
        #1;
        phase = run ? phase + 2'h1 : 2'h0;
        strobe = run & phase[1];
    end
endmodule

// ===== verif/tb_top.sv
// Self-checking testbench for the nibble delay configuration block.
// Assumes the design files and the strobe source model compile first.
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module tb_top;
    logic sys_clk, reset_n, strobeGateEnable, freeRunStrobe, coarseDelayEnable, selfCalEnable;
    logic phaseShiftP, phaseShiftN, inputDriftTrackingOff, driftCompRequest, readWindowEnable;
    logic strobeIn, gatedStrobe, gateReady, coarseApplied, inputDriftActive, laneCalibratedFlag;
    logic run, seen;
    logic [5:0] sliceJoin, sliceTxQtr, txEnabled, configError;
    logic [65:0] sliceDelayPs, inDelayPs, outDelayPs;
    int n_errors, compares, cycles;
    ndc_config i_dut (.sys_clk, .reset_n, .sliceJoin, .sliceDelayPs, .sliceTxQtr,
        .strobeGateEnable, .freeRunStrobe, .coarseDelayEnable, .selfCalEnable, .phaseShiftP,
        .phaseShiftN, .inputDriftTrackingOff, .driftCompRequest, .readWindowEnable, .strobeIn,
        .inDelayPs, .outDelayPs, .txEnabled, .gatedStrobe, .gateReady, .coarseApplied,
        .inputDriftActive, .laneCalibratedFlag, .configError);
    ndc_strobe_src i_src (.sys_clk(sys_clk), .run(run), .strobe(strobeIn));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // A hang is cut short well past the 130 or so cycles the tests need.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            complete_run();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic err(input logic [5:0] exp);
        step(2);
        chk("configError", {60'h0, exp}, {60'h0, configError});
    endtask
    task automatic wait_flag(input logic v, input int lim);
        int i;
        i = 0;
        while (laneCalibratedFlag !== v && i < lim)
        begin
            step(1);
            i++;
        end
        chk("laneCalibratedFlag", {65'h0, v}, {65'h0, laneCalibratedFlag});
    endtask
    task automatic test_split();
        sliceJoin = 6'h04;
        // The modelled bit clock is taken to run at 500 MHz or more, so taps are legal.
        sliceDelayPs = {33'h0, 11'h4E1, 11'h258, 11'h000};
        err(6'h00);
        chk("inDelayPs", {33'h0, 11'h270, 11'h258, 11'h0}, inDelayPs);
        chk("outDelayPs", {33'h0, 11'h271, 22'h0}, outDelayPs);
        chk("txEnabled", {60'h0, 6'h3B}, {60'h0, txEnabled});
        sliceDelayPs[33+:11] = 11'h272;
        err(6'h08);
        sliceDelayPs[33+:11] = 11'h000;
        sliceDelayPs[22+:11] = 11'h4E3;
        err(6'h08);
        sliceDelayPs[22+:11] = 11'h4E1;
    endtask
    task automatic test_errors();
        selfCalEnable = 1'b0;
        err(6'h01);
        selfCalEnable = 1'b1;
        sliceTxQtr = 6'h02;
        err(6'h20);
        sliceTxQtr = 6'h00;
        sliceDelayPs[10:0] = 11'h010;
        err(6'h10);
        sliceDelayPs[10:0] = 11'h000;
        coarseDelayEnable = 1'b1;
        phaseShiftP = 1'b1;
        phaseShiftN = 1'b1;
        err(6'h00);
        chk("coarseApplied", 66'h1, {65'h0, coarseApplied});
        phaseShiftN = 1'b0;
        err(6'h04);
        chk("coarseApplied", 66'h0, {65'h0, coarseApplied});
        phaseShiftN = 1'b1;
        selfCalEnable = 1'b0;
        err(6'h03);
        selfCalEnable = 1'b1;
        coarseDelayEnable = 1'b0;
        err(6'h00);
    endtask
    task automatic test_gate();
        strobeGateEnable = 1'b1;
        freeRunStrobe = 1'b1;
        run = 1'b1;
        readWindowEnable = 1'b1;
        step(5);
        chk("gateReady early", 66'h0, {65'h0, gateReady});
        step(30);
        chk("gateReady", 66'h1, {65'h0, gateReady});
        seen = 1'b0;
        repeat (8)
        begin
            step(1);
            seen |= gatedStrobe;
        end
        chk("gatedStrobe open", 66'h1, {65'h0, seen});
        readWindowEnable = 1'b0;
        step(4);
        seen = 1'b0;
        repeat (8)
        begin
            step(1);
            seen |= gatedStrobe;
        end
        chk("gatedStrobe shut", 66'h0, {65'h0, seen});
        freeRunStrobe = 1'b0;
        run = 1'b0;
        readWindowEnable = 1'b1;
        step(6);
        chk("gateReady burst", 66'h1, {65'h0, gateReady});
        readWindowEnable = 1'b0;
        strobeGateEnable = 1'b0;
        run = 1'b1;
        step(4);
        seen = 1'b0;
        repeat (8)
        begin
            step(1);
            seen |= gatedStrobe;
        end
        chk("gatedStrobe ungated", 66'h1, {65'h0, seen});
        run = 1'b0;
    endtask
    task automatic test_cal();
        driftCompRequest = 1'b1;
        step(2);
        chk("laneCalibratedFlag early", 66'h0, {65'h0, laneCalibratedFlag});
        wait_flag(1'b1, 20);
        step(2);
        chk("inputDriftActive", 66'h1, {65'h0, inputDriftActive});
        driftCompRequest = 1'b0;
        step(10);
        chk("laneCalibratedFlag held", 66'h1, {65'h0, laneCalibratedFlag});
        driftCompRequest = 1'b1;
        wait_flag(1'b0, 12);
        wait_flag(1'b1, 20);
        inputDriftTrackingOff = 1'b1;
        step(2);
        chk("inputDriftActive off", 66'h0, {65'h0, inputDriftActive});
    endtask
    initial
    begin
        {reset_n, strobeGateEnable, freeRunStrobe, coarseDelayEnable, phaseShiftP} = 5'h00;
        {phaseShiftN, inputDriftTrackingOff, driftCompRequest, readWindowEnable, run} = 5'h00;
        {sliceJoin, sliceTxQtr, sliceDelayPs} = 78'h0;
        selfCalEnable = 1'b1;
        step(6);
        chk("configError reset", 66'h0, {60'h0, configError});
        chk("txEnabled reset", 66'h0, {60'h0, txEnabled});
        reset_n = 1'b1;
        test_split();
        test_errors();
        test_gate();
        test_cal();
        complete_run();
    end
endmodule
